// ---- core/sct_control_two.v ----
// Purpose: second control register of the serial port with its request logic
// Assumes: register port and status inputs are on mclk; sck comes from a pin
// Notes:   dma and interrupt requests are levels, held while their cause holds
//
// Overview of operation
// R1 - rx dma request while enabled and not-empty
// R2 - tx dma request while enabled and empty
// R3 - select output driven in master when enabled
// R4 - select pulse between continuous frames
// R5 - single frame: select forced high at end
// R6 - pulse ignored with phase one or alternate
// R7 - software changes locked bits only when disabled
// R8 - frame format bit picks standard or alternate
// R9 - error interrupt only when error enable set
// R10 - rx not-empty interrupt when enabled
// R11 - tx empty interrupt when enabled
// R12 - frame width is field plus one
// R13 - reserved width codes stored as 0111
// R14 - threshold bit picks 16 or 8 bits
// R15 - last rx odd bit to packing logic
// R16 - last tx odd bit to packing logic
// R17 - last odd bits need rx dma, packing
// R18 - select settings void in audio, alternate
// R19 - width, format, threshold, last unused audio; width still sets frameWidth and the frame length in audio
// R20 - flags show not-empty and empty
// R21 - bit fifteen reads zero, writes ignored
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "sct_consts.vh"
module sct_control_two #(
  parameter PULSE_CYCLES = `SCT_PULSE_CYCLES
) (
  // clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  // serial core status, same clock
  input  wire [5:0]  rxFifoBits,
  input  wire        txBufEmpty,
  input  wire [3:0]  errFlags,
  input  wire        busy,
  // link pins
  input  wire        sckIn,
  output reg         selectOut,
  output reg         selectOe,
  // requests
  output reg         rxDmaReq,
  output reg         txDmaReq,
  output reg         irqReq,
  // configuration to the serial core
  output reg  [4:0]  frameWidth,
  output reg         frameFormatAlt,
  output reg         lastRxOdd,
  output reg         lastTxOdd,
  output reg         frameEnd
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [15:0] ctrlTwo_q;
  reg  [15:0] ctrlTwo_d;
  reg  [15:0] ctrlOne_q;
  reg  [15:0] ctrlOne_d;
  reg  [15:0] rdata_d;
  reg         sckPrev_q;
  wire        sckSync;
  wire        sckRise;
  wire        frameEndRaw;
  wire        selectHighRaw;

  // control-one view
  wire clockPhase = ctrlOne_q[`SCT_CLOCK_PHASE];
  wire masterMode = ctrlOne_q[`SCT_MASTER];
  wire portEnable = ctrlOne_q[`SCT_PORT_EN];
  wire audioMode  = ctrlOne_q[`SCT_AUDIO_MODE];
  wire packing    = ctrlOne_q[`SCT_PACKING];

  // control-two view
  wire rxDmaEn     = ctrlTwo_q[`SCT_RX_DMA_EN];
  wire txDmaEn     = ctrlTwo_q[`SCT_TX_DMA_EN];
  wire selOutEn    = ctrlTwo_q[`SCT_SEL_OUT_EN];
  wire selPulseEn  = ctrlTwo_q[`SCT_SEL_PULSE_EN];
  wire frameFmt    = ctrlTwo_q[`SCT_FRAME_FMT];
  wire errIrqEn    = ctrlTwo_q[`SCT_ERR_IRQ_EN];
  wire rxneIrqEn   = ctrlTwo_q[`SCT_RXNE_IRQ_EN];
  wire txeIrqEn    = ctrlTwo_q[`SCT_TXE_IRQ_EN];
  wire [3:0] widthField = ctrlTwo_q[`SCT_WIDTH_MSB:`SCT_WIDTH_LSB];
  wire rxThreshHalf = ctrlTwo_q[`SCT_RX_THRESH];
  wire lastRxField  = ctrlTwo_q[`SCT_LAST_RX_ODD];
  wire lastTxField  = ctrlTwo_q[`SCT_LAST_TX_ODD];

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // reserved codes collapse to an 8-bit frame
  function [3:0] legalWidth;
    input [3:0] code;
    begin
      if (code < `SCT_WIDTH_MIN)
        legalWidth = `SCT_WIDTH_FORCED; // R13
      else
        legalWidth = code;
    end
  endfunction

  function addrHit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addrHit = (addr == offset);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // derived state

  wire [5:0] rxLevel = rxThreshHalf ? `SCT_RX_LVL_HALF : `SCT_RX_LVL_FULL; // R14
  // audio mode has no threshold; any data counts
  wire rxNotEmpty = audioMode ? (rxFifoBits != 6'h00)
                              : (rxFifoBits >= rxLevel); // R14 R19 R20
  wire txEmpty    = txBufEmpty; // R20
  wire errAny     = |errFlags;
  wire altFormat  = frameFmt && !audioMode; // R8 R19
  wire pulseActive = selPulseEn && !clockPhase && !altFormat && !audioMode
                     && masterMode; // R6 R18
  wire selDrive   = masterMode && selOutEn && !altFormat && !audioMode; // R3 R18
  wire packActive = rxDmaEn && packing && !audioMode; // R17 R19

  //////////////////////////////////////////////////////////////////////////////
  // link clock edge detection

  sct_sync #(
    .WIDTH (1)
  ) u_sck_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn (sckIn),
    .syncOut (sckSync)
  );

  always @(posedge mclk)
  begin
    if (!resetn)
      sckPrev_q <= 1'b0;
    else
      sckPrev_q <= sckSync;
  end

  assign sckRise = sckSync && !sckPrev_q;

  sct_select #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_select (
    .mclk        (mclk),
    .resetn      (resetn),
    .busy        (busy),
    .sckRise     (sckRise),
    .frameWidth  ({1'b0, legalWidth(widthField)} + 5'h01),
    .txPending   (!txEmpty),
    .pulseActive (pulseActive),
    .frameEnd    (frameEndRaw),
    .selectHigh  (selectHighRaw)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always @*
  begin
    ctrlOne_d = ctrlOne_q;
    ctrlTwo_d = ctrlTwo_q;
    if (regWr && addrHit(regAddr, `SCT_OFF_CTRL_ONE))
      ctrlOne_d = regWdata & `SCT_CTRL_ONE_MASK;
    if (regWr && addrHit(regAddr, `SCT_OFF_CTRL_TWO))
    begin
      ctrlTwo_d = regWdata & `SCT_CTRL_TWO_MASK; // R21
      ctrlTwo_d[`SCT_WIDTH_MSB:`SCT_WIDTH_LSB] =
        legalWidth(regWdata[`SCT_WIDTH_MSB:`SCT_WIDTH_LSB]); // R12 R13
      // locked fields keep their value while the port runs
      if (portEnable)
      begin
        ctrlTwo_d[`SCT_SEL_PULSE_EN] = ctrlTwo_q[`SCT_SEL_PULSE_EN]; // R7
        ctrlTwo_d[`SCT_FRAME_FMT]    = ctrlTwo_q[`SCT_FRAME_FMT]; // R7
        ctrlTwo_d[`SCT_LAST_RX_ODD]  = ctrlTwo_q[`SCT_LAST_RX_ODD]; // R7
        ctrlTwo_d[`SCT_LAST_TX_ODD]  = ctrlTwo_q[`SCT_LAST_TX_ODD]; // R7
      end
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrlOne_q <= `SCT_CTRL_ONE_RST;
      ctrlTwo_q <= `SCT_CTRL_TWO_RST;
    end
    else
    begin
      ctrlOne_q <= ctrlOne_d;
      ctrlTwo_q <= ctrlTwo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads, data in the cycle after the strobe only

  always @*
  begin
    rdata_d = 16'h0000;
    if (regRd)
    begin
      if (addrHit(regAddr, `SCT_OFF_CTRL_ONE))
        rdata_d = ctrlOne_q;
      else if (addrHit(regAddr, `SCT_OFF_CTRL_TWO))
        rdata_d = ctrlTwo_q & `SCT_CTRL_TWO_MASK; // R21
      else if (addrHit(regAddr, `SCT_OFF_STATUS))
      begin
        rdata_d[`SCT_ST_RXNE] = rxNotEmpty; // R20
        rdata_d[`SCT_ST_TXE]  = txEmpty; // R20
        rdata_d[`SCT_ST_ERR]  = errAny;
        rdata_d[`SCT_ST_BUSY] = busy;
        rdata_d[`SCT_ST_SEL]  = selectHighRaw;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      regRdata       <= 16'h0000;
      rxDmaReq       <= 1'b0;
      txDmaReq       <= 1'b0;
      irqReq         <= 1'b0;
      frameWidth     <= 5'h08;
      frameFormatAlt <= 1'b0;
      lastRxOdd      <= 1'b0;
      lastTxOdd      <= 1'b0;
      selectOut      <= 1'b1;
      selectOe       <= 1'b0;
      frameEnd       <= 1'b0;
    end
    else
    begin
      regRdata       <= rdata_d;
      rxDmaReq       <= rxDmaEn && rxNotEmpty; // R1
      txDmaReq       <= txDmaEn && txEmpty; // R2
      irqReq         <= (errIrqEn && errAny) // R9
                        || (rxneIrqEn && rxNotEmpty) // R10
                        || (txeIrqEn && txEmpty); // R11
      frameWidth     <= {1'b0, widthField} + 5'h01; // R12
      frameFormatAlt <= altFormat; // R8
      lastRxOdd      <= packActive && lastRxField; // R15 R17
      lastTxOdd      <= packActive && lastTxField; // R16 R17
      // without pulse management the line is simply the inverse of busy
      selectOut      <= selectHighRaw; // R4 R5
      selectOe       <= selDrive; // R3
      frameEnd       <= frameEndRaw;
    end
  end

endmodule // sct_control_two

// ---- core/sct_consts.vh ----
// Purpose: constants for the second serial-port control register block
// Assumes: 16-bit register port, byte offsets as addresses
// Notes:   definitions only
`ifndef SCT_CONSTS_VH
`define SCT_CONSTS_VH

// register offsets
`define SCT_OFF_CTRL_ONE   8'h00
`define SCT_OFF_CTRL_TWO   8'h04
`define SCT_OFF_STATUS     8'h08

// serial_port_control_two fields
`define SCT_RX_DMA_EN      0
`define SCT_TX_DMA_EN      1
`define SCT_SEL_OUT_EN     2
`define SCT_SEL_PULSE_EN   3
`define SCT_FRAME_FMT      4
`define SCT_ERR_IRQ_EN     5
`define SCT_RXNE_IRQ_EN    6
`define SCT_TXE_IRQ_EN     7
`define SCT_WIDTH_LSB      8
`define SCT_WIDTH_MSB      11
`define SCT_RX_THRESH      12
`define SCT_LAST_RX_ODD    13
`define SCT_LAST_TX_ODD    14
`define SCT_CTRL_TWO_MASK  16'h7FFF
`define SCT_CTRL_TWO_RST   16'h0700
`define SCT_WIDTH_MIN      4'h3
`define SCT_WIDTH_FORCED   4'h7

// control-one subset fields
`define SCT_CLOCK_PHASE    0
`define SCT_MASTER         1
`define SCT_PORT_EN        2
`define SCT_AUDIO_MODE     3
`define SCT_PACKING        4
`define SCT_CTRL_ONE_MASK  16'h001F
`define SCT_CTRL_ONE_RST   16'h0000

// status fields
`define SCT_ST_RXNE        0
`define SCT_ST_TXE         1
`define SCT_ST_ERR         2
`define SCT_ST_BUSY        3
`define SCT_ST_SEL         4

// receive threshold levels in bits
`define SCT_RX_LVL_FULL    6'h10
`define SCT_RX_LVL_HALF    6'h08

// select pulse length
`define SCT_CLK_MHZ        50
`define SCT_PULSE_NS       160
`define SCT_PULSE_CYCLES   ((`SCT_PULSE_NS * `SCT_CLK_MHZ + 999) / 1000)

`endif

// ---- core/sct_sync.v ----
// Purpose: two-flop synchroniser for inputs from outside the mclk domain
// Assumes: inputs are slow levels compared with mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sct_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // data
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      stage1_q <= {WIDTH{1'b0}};
      syncOut  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule // sct_sync

// ---- core/sct_select.v ----
// Purpose: select-line sequencer for master transfers
// Assumes: sckRise is a one-cycle pulse on each sampled rising link clock edge
// Notes:   pulse length is counted in mclk cycles since the link clock idles
`timescale 1ns/1ps
`include "sct_consts.vh"
module sct_select #(
  parameter PULSE_CYCLES = `SCT_PULSE_CYCLES
) (
  // clock and reset
  input  wire       mclk,
  input  wire       resetn,
  // transfer state
  input  wire       busy,
  input  wire       sckRise,
  input  wire [4:0] frameWidth,
  input  wire       txPending,
  input  wire       pulseActive,
  // outputs
  output reg        frameEnd,
  output reg        selectHigh
);

  reg [4:0] bitCount_q;
  reg [7:0] pulseCount_q;
  reg       holdHigh_q;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      bitCount_q   <= 5'h00;
      pulseCount_q <= 8'h00;
      holdHigh_q   <= 1'b0;
      frameEnd     <= 1'b0;
      selectHigh   <= 1'b1;
    end
    else
    begin
      frameEnd <= 1'b0;
      if (!busy)
        bitCount_q <= 5'h00;
      else if (sckRise)
      begin
        if (bitCount_q == frameWidth - 5'h01)
        begin
          bitCount_q <= 5'h00;
          frameEnd   <= 1'b1;
          if (pulseActive)
          begin
            holdHigh_q   <= 1'b1;
            // continuous stream gets a short pulse, a lone frame stays high
            pulseCount_q <= txPending ? PULSE_CYCLES[7:0] : 8'h00; // R4 R5
          end
        end
        else
          bitCount_q <= bitCount_q + 5'h01;
      end
      if (holdHigh_q && pulseCount_q != 8'h00)
      begin
        pulseCount_q <= pulseCount_q - 8'h01;
        if (pulseCount_q == 8'h01)
          holdHigh_q <= 1'b0; // R4
      end
      if (!busy)
        holdHigh_q <= 1'b0;
      selectHigh <= !busy || holdHigh_q; // R5
    end
  end

endmodule // sct_select

// ---- verif/sct_checker.sv ----
// Purpose: port checks of the control-two block
// Assumes: one mclk domain, sync active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module sct_checker (
  // clock and reset
  input wire        mclk,
  input wire        resetn,
  // register port
  input wire [7:0]  regAddr,
  input wire [15:0] regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [15:0] regRdata,
  // status
  input wire [5:0]  rxFifoBits,
  input wire        txBufEmpty,
  input wire [3:0]  errFlags,
  input wire        busy,
  // results
  input wire        selectOut,
  input wire        rxDmaReq,
  input wire        txDmaReq,
  input wire        irqReq,
  input wire [4:0]  frameWidth,
  input wire        frameEnd
);
  wire [3:0] wrCode = regWdata[11:8];
  wire       anyCause = txBufEmpty | (|errFlags) | (|rxFifoBits);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  a_rx_dma_cause: assert property (rxDmaReq |-> $past(rxFifoBits) != 6'h00)
    else $error("rx dma request without data");
  a_tx_dma_cause: assert property (txDmaReq |-> $past(txBufEmpty))
    else $error("tx dma request while buffer full");
  a_irq_cause: assert property (irqReq |-> $past(anyCause))
    else $error("interrupt without cause");
  a_width_write: assert property (regWr && regAddr == 8'h04 |-> ##2
    frameWidth == (($past(wrCode, 2) < 4'h3) ? 5'h08 : {1'h0, $past(wrCode, 2)} + 5'h01))
    else $error("frame width not taken from write");
  a_width_range: assert property (frameWidth >= 5'h04 && frameWidth <= 5'h10)
    else $error("frame width out of range");
  a_sel_idle: assert property (!busy [*3] |-> selectOut)
    else $error("select low while idle");
  a_bit15_zero: assert property ($past(regRd) |-> !regRdata[15])
    else $error("reserved bit read as one");
  a_rd_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property ($past(regRd) && $past(regAddr) > 8'h08 |-> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  c_frame_end: cover property (frameEnd);
  c_rx_dma: cover property (rxDmaReq);
  c_irq: cover property (irqReq);
endmodule // sct_checker

// ---- verif/sct_link_partner.sv ----
// Purpose: far-side link clock source
// Assumes: run is high only while a frame moves
// Notes:   3 ns offset keeps link edges off mclk edges
`timescale 1ns/1ps
module sct_link_partner (
  // control
  input wire run,
  // link
  output reg sck
);
  // clock stands still low between frames
  initial
  begin
    sck = 1'h0;
    #3;
    forever
    begin
      #80;
      sck = run ? ~sck : 1'h0;
    end
  end
endmodule // sct_link_partner

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for sct_control_two
// Assumes: 50 MHz mclk, link clock from the partner
// Notes:   reset check first, then request table, then hand tests
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] c;
    logic [5:0]  b;
    logic        t;
    logic [3:0]  e;
    logic [3:0]  x;
  } sct_row_t;
  reg         mclk;
  reg         resetn;
  reg  [7:0]  regAddr;
  reg  [15:0] regWdata;
  reg         regWr;
  reg         regRd;
  reg  [5:0]  rxFifoBits;
  reg         txBufEmpty;
  reg  [3:0]  errFlags;
  reg         busy;
  reg         run;
  reg  [3:0]  code;
  wire        sckIn;
  wire [15:0] regRdata;
  wire [4:0]  frameWidth;
  wire        selectOut, selectOe, rxDmaReq, txDmaReq, irqReq;
  wire        frameFormatAlt, lastRxOdd, lastTxOdd, frameEnd;
  int         error_cnt;
  int         checks_done;
  int         n;
  sct_row_t   rows [10];

  sct_control_two uut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxFifoBits(rxFifoBits),
    .txBufEmpty(txBufEmpty), .errFlags(errFlags), .busy(busy), .sckIn(sckIn),
    .selectOut(selectOut), .selectOe(selectOe), .rxDmaReq(rxDmaReq), .txDmaReq(txDmaReq),
    .irqReq(irqReq), .frameWidth(frameWidth), .frameFormatAlt(frameFormatAlt),
    .lastRxOdd(lastRxOdd), .lastTxOdd(lastTxOdd), .frameEnd(frameEnd));
  sct_link_partner far (.run(run), .sck(sckIn));

  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task cmp(input [15:0] g, input [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge mclk);
    regRd <= 1'h0;
    #1 cmp(regRdata, e);
  endtask
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task frame_wait;
    n = 0;
    while (frameEnd !== 1'h1 && n < 400)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200000;
    error_cnt++;
    summarize;
  end
  initial
  begin
    {resetn, regAddr, regWdata, regWr, regRd, rxFifoBits} = '0;
    {txBufEmpty, errFlags, busy, run} = '0;
    rows[0] = '{16'h0701, 6'h10, 1'h0, 4'h0, 4'h8};
    rows[1] = '{16'h0701, 6'h0F, 1'h0, 4'h0, 4'h0};
    rows[2] = '{16'h1701, 6'h08, 1'h0, 4'h0, 4'h8};
    rows[3] = '{16'h1701, 6'h07, 1'h0, 4'h0, 4'h0};
    rows[4] = '{16'h0702, 6'h00, 1'h1, 4'h0, 4'h4};
    rows[5] = '{16'h0700, 6'h00, 1'h1, 4'h0, 4'h0};
    rows[6] = '{16'h0720, 6'h00, 1'h0, 4'h1, 4'h2};
    rows[7] = '{16'h0700, 6'h00, 1'h0, 4'hF, 4'h0};
    rows[8] = '{16'h0740, 6'h10, 1'h0, 4'h0, 4'h2};
    rows[9] = '{16'h0790, 6'h00, 1'h1, 4'h0, 4'h3};
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    rd(8'h04, 16'h0700);
    cmp(frameWidth, 16'h0008);
    cmp(selectOut, 16'h0001);
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(8'h04, rows[i].c);
      @(posedge mclk);
      rxFifoBits <= rows[i].b;
      txBufEmpty <= rows[i].t;
      errFlags <= rows[i].e;
      settle;
      cmp({rxDmaReq, txDmaReq, irqReq, frameFormatAlt}, rows[i].x);
    end
    @(posedge mclk);
    {rxFifoBits, txBufEmpty, errFlags} <= '0;
    $display("request table done");
    for (int i = 0; i < 16; i++)
    begin
      code = (i < 3) ? 4'h7 : 4'(i);
      wr(8'h04, {4'h8, 4'(i), 8'h00});
      rd(8'h04, {4'h0, code, 8'h00});
      cmp(frameWidth, 16'(code) + 16'h0001);
    end
    rd(8'h0C, 16'h0000);
    wr(8'h0C, 16'hFFFF);
    rd(8'h04, 16'h0F00);
    $display("width codes done");
    wr(8'h00, 16'h0004);
    wr(8'h04, 16'h6A18);
    rd(8'h04, 16'h0A00);
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h6A18);
    rd(8'h04, 16'h6A18);
    $display("locked bits done");
    wr(8'h00, 16'h0010);
    wr(8'h04, 16'h6701);
    settle;
    cmp({lastRxOdd, lastTxOdd}, 16'h0003);
    wr(8'h04, 16'h6700);
    settle;
    cmp({lastRxOdd, lastTxOdd}, 16'h0000);
    wr(8'h00, 16'h0018);
    wr(8'h04, 16'h6711);
    @(posedge mclk);
    rxFifoBits <= 6'h01;
    settle;
    cmp({rxDmaReq, frameFormatAlt, lastRxOdd}, 16'h0004);
    wr(8'h00, 16'h000A);
    wr(8'h04, 16'h0704);
    settle;
    cmp(selectOe, 16'h0000);
    wr(8'h00, 16'h0002);
    wr(8'h04, 16'h0714);
    @(posedge mclk);
    rxFifoBits <= 6'h10;
    txBufEmpty <= 1'h1;
    settle;
    cmp(selectOe, 16'h0000);
    rd(8'h08, 16'h0013);
    @(posedge mclk);
    {rxFifoBits, txBufEmpty} <= '0;
    $display("packing and audio done");
    wr(8'h00, 16'h0002);
    wr(8'h04, 16'h0704);
    settle;
    cmp(selectOe, 16'h0001);
    wr(8'h04, 16'h0708);
    settle;
    cmp(selectOe, 16'h0000);
    wr(8'h00, 16'h0006);
    @(posedge mclk);
    txBufEmpty <= 1'h1;
    busy <= 1'h1;
    run <= 1'h1;
    frame_wait;
    run <= 1'h0;
    cmp(n < 400, 16'h0001);
    settle;
    cmp(selectOut, 16'h0001);
    @(posedge mclk);
    busy <= 1'h0;
    $display("single frame done");
    @(posedge mclk);
    txBufEmpty <= 1'h0;
    busy <= 1'h1;
    run <= 1'h1;
    frame_wait;
    cmp(n < 400, 16'h0001);
    repeat (2) @(posedge mclk);
    #1 cmp(selectOut, 16'h0001);
    // pulse lasts eight mclk cycles, then the line drops for the next frame
    repeat (7) @(posedge mclk);
    #1 cmp(selectOut, 16'h0000);
    @(posedge mclk);
    busy <= 1'h0;
    run <= 1'h0;
    wr(8'h00, 16'h0007);
    @(posedge mclk);
    txBufEmpty <= 1'h1;
    busy <= 1'h1;
    run <= 1'h1;
    frame_wait;
    settle;
    cmp({n < 400, selectOut}, 16'h0002);
    @(posedge mclk);
    busy <= 1'h0;
    run <= 1'h0;
    $display("pulse tests done");
    @(posedge mclk);
    resetn <= 1'h0;
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    rd(8'h04, 16'h0700);
    $display("second reset done");
    summarize;
  end
endmodule // testbench

bind sct_control_two sct_checker chk (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .rxFifoBits(rxFifoBits), .txBufEmpty(txBufEmpty), .errFlags(errFlags), .busy(busy),
  .selectOut(selectOut), .rxDmaReq(rxDmaReq), .txDmaReq(txDmaReq), .irqReq(irqReq),
  .frameWidth(frameWidth), .frameEnd(frameEnd));
